/* File: hdl/cpmc_defines.svh */
`ifndef CPMC_DEFINES_SVH
`define CPMC_DEFINES_SVH

// Register indices; byte address is four times the index.
`define CPMC_IDX_DATA    3'h0
`define CPMC_IDX_CTRL    3'h1
`define CPMC_IDX_RSVA    3'h2
`define CPMC_IDX_STAT    3'h3
`define CPMC_IDX_RSVB    3'h4
`define CPMC_IDX_RSVC    3'h5
`define CPMC_IDX_IEN     3'h6
`define CPMC_IDX_IFLG    3'h7
// Word index field of the byte address and size of the window.
`define CPMC_AW          5
`define CPMC_IDX_LO      2
`define CPMC_IDX_HI      4
// Control register fields.
`define CPMC_CTRL_EN     7
`define CPMC_CTRL_TERM   6
`define CPMC_CTRL_WU_HI  5
`define CPMC_CTRL_WU_LO  4
`define CPMC_CTRL_SLR_HI 2
`define CPMC_CTRL_SLR_LO 0
`define CPMC_CTRL_MASK   8'hf7
`define CPMC_CTRL_RST    8'h20
// Data register fields.
`define CPMC_DATA_WU     7
`define CPMC_DATA_TX     1
`define CPMC_DATA_RX     0
// Status and flag fields.
`define CPMC_ST_DT       3
`define CPMC_IE_VF       4
`define CPMC_IE_DT       3
`define CPMC_IE_OC       0
`define CPMC_IE_MASK     8'h19
`define CPMC_IF_VF_MASK  8'hf0
`define CPMC_IF_DT_MASK  8'h08
`define CPMC_IF_OC_MASK  8'h03
// Wake-up filter select encodings.
`define CPMC_WU_OFF      2'h0
`define CPMC_WU_NOFILT   2'h2
`define CPMC_WU_MASK1    2'h1
`define CPMC_WU_MASK2    2'h3
// Dominant timeout on the transmit input.
`define CPMC_DT_TIME_US  16'h0100
`define CPMC_CLK_MHZ     16'h007d
`define CPMC_DT_CYCLES   (`CPMC_DT_TIME_US * `CPMC_CLK_MHZ)
`define CPMC_DT_W        16
// AHB-Lite encodings.
`define CPMC_HTRANS_NSEQ 2'h2
`define CPMC_HSIZE_WORD  3'h2

`endif

/* File: hdl/cpmc_pkg.sv */
package cpmc_pkg;

  // Operating modes of the transceiver, one-hot.
  typedef enum logic [4:0] {
    CPMC_SHUTDOWN  = 5'h01,
    CPMC_NORMAL    = 5'h02,
    CPMC_PSEUDO    = 5'h04,
    CPMC_LISTEN    = 5'h08,
    CPMC_STANDBY   = 5'h10
  } cpmc_mode_t;

endpackage : cpmc_pkg

/* File: hdl/cpmc_can_phy_mode_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpmc_defines.svh"

module cpmc_can_phy_mode_control (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ctrl_tx_out,
  output logic             ctrl_rx_in,
  input  wire logic        tx_route_data,
  input  wire logic        cpu_wait,
  input  wire logic        cpu_stop_req,
  input  wire logic        regulator_reduced_state,
  input  wire logic        precise_rx,
  input  wire logic        wakeup_rx,
  input  wire logic        special_mode,
  input  wire logic        pseudo_sel,
  input  wire logic        listen_sel,
  input  wire logic [3:0]  volt_fail,
  input  wire logic [1:0]  over_current,
  output logic             phy_tx_in,
  output logic             drive_high_en,
  output logic             drive_low_en,
  output logic             rx_bias_en,
  output logic             wakeup_rx_en,
  output logic             termination_bias_en,
  output logic [2:0]       slew_select,
  output logic             irq
);

  // Register storage.
  logic [7:0]             ctrlReg;
  logic                   txDriveBit;
  logic [7:0]             testReg;
  logic [7:0]             ienReg;
  logic [7:0]             iflgReg;
  logic                   dtStatus;
  cpmc_pkg::cpmc_mode_t   mode;
  cpmc_pkg::cpmc_mode_t   next_mode;
  logic                   stopPending;
  logic [1:0]             maskLeft;
  logic                   wuPrev;
  logic                   filtRx;
  logic [`CPMC_DT_W-1:0]  dtCount;
  logic                   txSrc;
  logic                   phyRxOut;
  logic                   wrPend;
  logic                   rdPend;
  logic [2:0]             idxPend;
  logic [2:0]             idxNow;
  logic                   takeNow;

  // Word index of a byte address inside the eight-register window.
  function automatic logic [2:0] cpmcIndex(input logic [31:0] a);
    cpmcIndex = a[`CPMC_IDX_HI:`CPMC_IDX_LO];
  endfunction : cpmcIndex

  // True when address lies inside the eight-word window.
  function automatic logic cpmcInWindow(input logic [31:0] a);
    cpmcInWindow = (a[31:`CPMC_AW] == 27'h0000000);
  endfunction : cpmcInWindow

  // The slave never stalls, so each transfer takes one data-phase cycle.
  assign idxNow  = cpmcIndex(haddr);
  assign takeNow = hsel && hready && (htrans == `CPMC_HTRANS_NSEQ)
                   && (hsize == `CPMC_HSIZE_WORD) && cpmcInWindow(haddr);

  // Address phase is latched; data-phase write lands one edge later.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPend  <= 1'b0;
      rdPend  <= 1'b0;
      idxPend <= 3'h0;
    end else if (hready) begin
      wrPend  <= takeNow && hwrite;
      rdPend  <= takeNow && !hwrite;
      idxPend <= idxNow;
    end
  end

  // Bus answer is always OKAY with zero wait states.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is produced in the address phase so it stands in the data phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (takeNow && !hwrite) begin
      case (idxNow)
        `CPMC_IDX_DATA: hrdata <= {24'h000000, wakeup_rx, 5'h00,
                                   txDriveBit, phyRxOut};
        `CPMC_IDX_CTRL: hrdata <= {24'h000000, ctrlReg};
        `CPMC_IDX_RSVA: hrdata <= {24'h000000, testReg};
        `CPMC_IDX_STAT: hrdata <= {24'h000000, volt_fail, dtStatus, 3'h0};
        `CPMC_IDX_IEN:  hrdata <= {24'h000000, ienReg};
        `CPMC_IDX_IFLG: hrdata <= {24'h000000, iflgReg};
        default:        hrdata <= 32'h00000000;
      endcase
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // Control register; the enable bit can be set but never cleared.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlReg <= `CPMC_CTRL_RST;
    end else if (wrPend && idxPend == `CPMC_IDX_CTRL) begin
      ctrlReg <= (hwdata[7:0] & `CPMC_CTRL_MASK)
                 | {ctrlReg[`CPMC_CTRL_EN], 7'h00};
    end
  end

  // Data register drive bit, reset recessive so the bus is left idle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txDriveBit <= 1'b1;
    end else if (wrPend && idxPend == `CPMC_IDX_DATA) begin
      txDriveBit <= hwdata[`CPMC_DATA_TX];
    end
  end

  // Factory test register accepts writes only in special mode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      testReg <= 8'h00;
    end else if (wrPend && idxPend == `CPMC_IDX_RSVA && special_mode) begin
      testReg <= hwdata[7:0];
    end
  end

  // Interrupt enables.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ienReg <= 8'h00;
    end else if (wrPend && idxPend == `CPMC_IDX_IEN) begin
      ienReg <= hwdata[7:0] & `CPMC_IE_MASK;
    end
  end

  // Flags clear by writing one; a new event in the same cycle wins.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iflgReg <= 8'h00;
    end else begin
      iflgReg <= (iflgReg & ~((wrPend && idxPend == `CPMC_IDX_IFLG)
                  ? hwdata[7:0] : 8'h00))
                 | {volt_fail, (dtCount == `CPMC_DT_W'(`CPMC_DT_CYCLES)),
                    1'b0, over_current};
    end
  end

  // The interrupt is registered so that it comes straight from a flop.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(iflgReg & `CPMC_IF_VF_MASK) && ienReg[`CPMC_IE_VF])
          || (|(iflgReg & `CPMC_IF_DT_MASK) && ienReg[`CPMC_IE_DT])
          || (|(iflgReg & `CPMC_IF_OC_MASK) && ienReg[`CPMC_IE_OC]);
    end
  end

  // Transmit source: controller by default, data bit when routed.
  assign txSrc = tx_route_data ? txDriveBit : ctrl_tx_out;

  // Dominant timeout counter saturates; it releases on a recessive input.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dtCount <= '0;
    end else if (txSrc || mode != cpmc_pkg::CPMC_NORMAL
                 && mode != cpmc_pkg::CPMC_PSEUDO) begin
      dtCount <= '0;
    end else if (dtCount != `CPMC_DT_W'(`CPMC_DT_CYCLES)) begin
      dtCount <= dtCount + `CPMC_DT_W'(1);
    end
  end

  // Timeout status follows the counter so software sees it live.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dtStatus <= 1'b0;
    end else begin
      dtStatus <= (dtCount == `CPMC_DT_W'(`CPMC_DT_CYCLES));
    end
  end

  // A stop request is registered one cycle late and clears one cycle after the request drops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stopPending <= 1'b0;
    end else if (!cpu_stop_req) begin
      stopPending <= 1'b0;
    end else begin
      stopPending <= 1'b1;
    end
  end

  // Mode choice; wait mode is deliberately ignored.
  always_comb begin
    next_mode = mode;
    case (mode)
      cpmc_pkg::CPMC_SHUTDOWN: begin
        if (ctrlReg[`CPMC_CTRL_EN]) begin
          next_mode = cpmc_pkg::CPMC_NORMAL;
        end
      end
      cpmc_pkg::CPMC_NORMAL, cpmc_pkg::CPMC_PSEUDO,
      cpmc_pkg::CPMC_LISTEN: begin
        if (stopPending && regulator_reduced_state) begin
          next_mode = cpmc_pkg::CPMC_STANDBY;
        end else if (listen_sel) begin
          next_mode = cpmc_pkg::CPMC_LISTEN;
        end else if (pseudo_sel) begin
          next_mode = cpmc_pkg::CPMC_PSEUDO;
        end else begin
          next_mode = cpmc_pkg::CPMC_NORMAL;
        end
      end
      cpmc_pkg::CPMC_STANDBY: begin
        if (!cpu_stop_req && !regulator_reduced_state) begin
          next_mode = cpmc_pkg::CPMC_NORMAL;
        end
      end
      default: next_mode = cpmc_pkg::CPMC_SHUTDOWN;
    endcase
  end

  // Mode register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= cpmc_pkg::CPMC_SHUTDOWN;
    end else begin
      mode <= next_mode;
    end
  end

  // Wake-up mask count is loaded at stop entry, before standby begins.
  // An event is counted as it ends, so a masked pulse stays hidden whole.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      maskLeft <= 2'h0;
    end else if (cpu_stop_req && !stopPending) begin
      case (ctrlReg[`CPMC_CTRL_WU_HI:`CPMC_CTRL_WU_LO])
        `CPMC_WU_MASK1: maskLeft <= 2'h1;
        `CPMC_WU_MASK2: maskLeft <= 2'h2;
        default:        maskLeft <= 2'h0;
      endcase
    end else if (mode == cpmc_pkg::CPMC_STANDBY && !wuPrev && wakeup_rx
                 && maskLeft != 2'h0) begin
      maskLeft <= maskLeft - 2'h1;
    end
  end

  // Filtered wake-up path: masked dominant events read as recessive.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wuPrev <= 1'b1;
      filtRx <= 1'b1;
    end else begin
      wuPrev <= wakeup_rx;
      filtRx <= (maskLeft != 2'h0) ? 1'b1 : wakeup_rx;
    end
  end

  // Receive source: wake-up path in standby, recessive in shutdown, precision receiver elsewhere.
  assign phyRxOut = (mode == cpmc_pkg::CPMC_STANDBY) ? filtRx
                  : (mode == cpmc_pkg::CPMC_SHUTDOWN) ? 1'b1
                  : precise_rx;

  // Transceiver drive controls, all from flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_tx_in           <= 1'b1;
      ctrl_rx_in          <= 1'b1;
      drive_high_en       <= 1'b0;
      drive_low_en        <= 1'b0;
      rx_bias_en          <= 1'b0;
      wakeup_rx_en        <= 1'b0;
      termination_bias_en <= 1'b0;
      slew_select         <= 3'h0;
    end else begin
      phy_tx_in     <= txSrc || (dtCount == `CPMC_DT_W'(`CPMC_DT_CYCLES));
      ctrl_rx_in    <= phyRxOut;
      drive_high_en <= !txSrc && (dtCount != `CPMC_DT_W'(`CPMC_DT_CYCLES))
                       && (mode == cpmc_pkg::CPMC_NORMAL
                           || mode == cpmc_pkg::CPMC_PSEUDO);
      drive_low_en  <= !txSrc && (dtCount != `CPMC_DT_W'(`CPMC_DT_CYCLES))
                       && mode == cpmc_pkg::CPMC_NORMAL;
      rx_bias_en    <= mode == cpmc_pkg::CPMC_NORMAL
                       || mode == cpmc_pkg::CPMC_PSEUDO
                       || mode == cpmc_pkg::CPMC_LISTEN;
      wakeup_rx_en  <= mode != cpmc_pkg::CPMC_SHUTDOWN
                       && ctrlReg[`CPMC_CTRL_WU_HI:`CPMC_CTRL_WU_LO]
                          != `CPMC_WU_OFF;
      termination_bias_en <= ctrlReg[`CPMC_CTRL_TERM]
                       && (mode == cpmc_pkg::CPMC_NORMAL
                           || mode == cpmc_pkg::CPMC_LISTEN);
      slew_select   <= ctrlReg[`CPMC_CTRL_SLR_HI:`CPMC_CTRL_SLR_LO];
    end
  end

  // Shutdown never biases the bus drivers.
  a_shutdown_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    $past(mode) == cpmc_pkg::CPMC_SHUTDOWN |-> !drive_high_en && !rx_bias_en)
    else $error("Drivers biased in shutdown.");
  // Listen-only never drives.
  a_listen_nodrive: assert property (@(posedge clk) disable iff (sys_rst)
    $past(mode) == cpmc_pkg::CPMC_LISTEN |-> !drive_high_en && !drive_low_en)
    else $error("Bus driven in listen-only.");
  // Pseudo-normal keeps the low side off.
  a_pseudo_lowoff: assert property (@(posedge clk) disable iff (sys_rst)
    $past(mode) == cpmc_pkg::CPMC_PSEUDO |-> !drive_low_en)
    else $error("Low driver on in pseudo-normal.");
  // Enable bit once set stays set.
  a_enable_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    ctrlReg[`CPMC_CTRL_EN] |=> ctrlReg[`CPMC_CTRL_EN])
    else $error("Enable bit cleared.");
  // Enable leaves shutdown on the next edge.
  a_enable_normal: assert property (@(posedge clk) disable iff (sys_rst)
    mode == cpmc_pkg::CPMC_SHUTDOWN && ctrlReg[`CPMC_CTRL_EN]
    |=> mode == cpmc_pkg::CPMC_NORMAL)
    else $error("Shutdown not left after enable.");
  // Stop plus reduced regulator gives standby next cycle.
  a_stop_standby: assert property (@(posedge clk) disable iff (sys_rst)
    stopPending && regulator_reduced_state && mode != cpmc_pkg::CPMC_SHUTDOWN
    |=> mode == cpmc_pkg::CPMC_STANDBY)
    else $error("Standby not entered.");
  // Receive in normal tracks precision receiver.
  a_rx_precise: assert property (@(posedge clk) disable iff (sys_rst)
    mode == cpmc_pkg::CPMC_NORMAL |=> ctrl_rx_in == $past(precise_rx))
    else $error("Receive not from precision path.");
  // Enabled flag raises the interrupt next cycle.
  a_irq_timeout: assert property (@(posedge clk) disable iff (sys_rst)
    iflgReg[`CPMC_ST_DT] && ienReg[`CPMC_IE_DT] |=> irq)
    else $error("Timeout interrupt missing.");

endmodule : cpmc_can_phy_mode_control
`default_nettype wire

/* File: verification/cpmc_can_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Shared bus lines as seen by this node, plus one remote node.
// An unbiased receiver reads recessive here; the real part promises
// nothing there, yet the standby check with wake-up off leans on that level.
module cpmc_can_bus_model (
  input  wire logic driveHighEn,
  input  wire logic driveLowEn,
  input  wire logic rxBiasEn,
  input  wire logic wakeupRxEn,
  input  wire logic remoteDom,
  output logic      preciseRx,
  output logic      wakeupRx
);
  logic busDom;

  // Any enabled driver, ours or the remote one, makes the bus dominant.
  assign busDom = driveHighEn | driveLowEn | remoteDom;
  // Receivers report low for dominant, and only while biased.
  assign preciseRx = rxBiasEn ? ~busDom : 1'b1;
  assign wakeupRx = wakeupRxEn ? ~busDom : 1'b1;
endmodule : cpmc_can_bus_model

`default_nettype wire

/* File: verification/cpmc_can_phy_mode_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module cpmc_can_phy_mode_control_tb_top;
  logic        clk, sysRst, hsel, hwrite, ctrlTxOut, txRouteData, cpuWait;
  logic        cpuStopReq, regReduced, specialMode, pseudoSel, listenSel;
  logic        remoteDom;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans, overCurrent;
  logic [2:0]  hsize;
  logic [3:0]  voltFail;
  wire  logic  hready, hreadyout, hresp, ctrlRxIn, preciseRx, wakeupRx;
  wire  logic  phyTxIn, irq, driveHighEn, driveLowEn, rxBiasEn;
  wire  logic  wakeupRxEn, termBiasEn;
  wire  logic [31:0] hrdata;
  wire  logic [2:0]  slewSelect;
  wire  logic [4:0]  enVec;
  int          errTotal = 0;
  int          samplesChecked = 0;
  int          cycles = 0;

  // Single slave, so its ready is the bus ready.
  assign hready = hreadyout;
  assign enVec = {driveHighEn, driveLowEn, rxBiasEn, wakeupRxEn, termBiasEn};

  cpmc_can_phy_mode_control u_dut (
    .clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ctrl_tx_out(ctrlTxOut), .ctrl_rx_in(ctrlRxIn),
    .tx_route_data(txRouteData), .cpu_wait(cpuWait),
    .cpu_stop_req(cpuStopReq), .regulator_reduced_state(regReduced),
    .precise_rx(preciseRx), .wakeup_rx(wakeupRx),
    .special_mode(specialMode), .pseudo_sel(pseudoSel),
    .listen_sel(listenSel), .volt_fail(voltFail),
    .over_current(overCurrent), .phy_tx_in(phyTxIn),
    .drive_high_en(driveHighEn), .drive_low_en(driveLowEn),
    .rx_bias_en(rxBiasEn), .wakeup_rx_en(wakeupRxEn),
    .termination_bias_en(termBiasEn), .slew_select(slewSelect), .irq(irq)
  );

  cpmc_can_bus_model u_bus (
    .driveHighEn(driveHighEn), .driveLowEn(driveLowEn),
    .rxBiasEn(rxBiasEn), .wakeupRxEn(wakeupRxEn), .remoteDom(remoteDom),
    .preciseRx(preciseRx), .wakeupRx(wakeupRx)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard; the long dominant hold alone takes about 32000 cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errTotal++;
      printVerdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One single word transfer; the master waits on ready, not on a count.
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= wr;
    haddr <= a;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wreg(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask : wreg

  task automatic rchk(input string nm, input logic [31:0] a,
                      input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(nm, exp, d);
  endtask : rchk

  // Shutdown stays unbiased even with the controller sending dominant.
  task automatic t_reset;
    ctrlTxOut <= 1'b0;
    rchk("ctrl reset", 32'h4, 32'h20);
    rchk("unmapped read", 32'h40, 32'h0);
    chk("okay resp", 1'b0, hresp);
    chk("ready", 1'b1, hready);
    tick(4);
    chk("shutdown bias", 5'h0, enVec);
    chk("rx idle", 1'b1, ctrlRxIn);
    ctrlTxOut <= 1'b1;
    tick(4);
  endtask : t_reset

  // Enable, drive dominant, then try to clear the one-shot enable.
  task automatic t_normal;
    wreg(32'h4, 32'he5);
    tick(4);
    rchk("ctrl value", 32'h4, 32'he5);
    chk("slew", 3'h5, slewSelect);
    chk("normal idle", 5'h05, enVec & 5'h1d);
    ctrlTxOut <= 1'b0;
    tick(4);
    chk("tx in", 1'b0, phyTxIn);
    chk("normal drive", 5'h1d, enVec & 5'h1d);
    chk("rx echo", 1'b0, ctrlRxIn);
    ctrlTxOut <= 1'b1;
    wreg(32'h4, 32'h65);
    rchk("enable sticks", 32'h4, 32'he5);
    tick(4);
    chk("rx recessive", 1'b1, ctrlRxIn);
  endtask : t_normal

  // Pseudo-normal, listen-only, then normal under processor wait.
  task automatic t_submodes;
    logic [4:0] expEn [3] = '{5'h14, 5'h05, 5'h1d};
    logic       expRx [3] = '{1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      pseudoSel <= (i == 0);
      listenSel <= (i == 1);
      cpuWait <= (i == 2);
      ctrlTxOut <= 1'b0;
      tick(4);
      chk("sub-mode drive", expEn[i], enVec & 5'h1d);
      chk("sub-mode rx", expRx[i], ctrlRxIn);
      ctrlTxOut <= 1'b1;
      tick(4);
    end
    cpuWait <= 1'b0;
    listenSel <= 1'b0;
  endtask : t_submodes

  // The data bit takes over the transmit input when routed there.
  task automatic t_route;
    txRouteData <= 1'b1;
    wreg(32'h0, 32'h0);
    tick(4);
    chk("routed dominant", 1'b0, phyTxIn);
    wreg(32'h0, 32'h2);
    tick(4);
    chk("routed recessive", 1'b1, phyTxIn);
    rchk("data reg", 32'h0, 32'h83);
    txRouteData <= 1'b0;
    // The test register only takes writes in special mode.
    wreg(32'h8, 32'h5a);
    rchk("test locked", 32'h8, 32'h0);
    specialMode <= 1'b1;
    wreg(32'h8, 32'h5a);
    specialMode <= 1'b0;
    rchk("test write", 32'h8, 32'h5a);
  endtask : t_route

  // Every wake-up select code, three remote pulses in each standby stay.
  task automatic t_standby;
    logic [1:0] code [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    int         masked [4] = '{0, 1, 2, 3};
    for (int i = 0; i < 4; i++) begin
      wreg(32'h4, {24'h0, 2'h3, code[i], 4'h5});
      cpuStopReq <= 1'b1;
      tick(4);
      chk("stop waits", 1'b1, rxBiasEn);
      regReduced <= 1'b1;
      tick(4);
      chk("standby bias", {3'h0, code[i] != 2'h0, 1'b0}, enVec);
      for (int k = 0; k < 3; k++) begin
        remoteDom <= 1'b1;
        tick(6);
        chk("wake pulse", k < masked[i], ctrlRxIn);
        remoteDom <= 1'b0;
        tick(6);
      end
      cpuStopReq <= 1'b0;
      regReduced <= 1'b0;
      tick(4);
    end
  endtask : t_standby

  // Monitor flags, masking, clearing and the dominant hold limit.
  task automatic t_irq;
    wreg(32'h18, 32'h19);
    rchk("irq enable", 32'h18, 32'h19);
    voltFail <= 4'h8;
    tick(4);
    rchk("volt status", 32'hc, 32'h80);
    voltFail <= 4'h0;
    tick(4);
    rchk("volt flag", 32'h1c, 32'h80);
    chk("volt irq", 1'b1, irq);
    wreg(32'h1c, 32'h80);
    tick(4);
    chk("irq cleared", 1'b0, irq);
    overCurrent <= 2'h1;
    tick(2);
    overCurrent <= 2'h0;
    tick(4);
    rchk("current flag", 32'h1c, 32'h01);
    chk("current irq", 1'b1, irq);
    wreg(32'h1c, 32'hff);
    wreg(32'h18, 32'h08);
    voltFail <= 4'h1;
    tick(2);
    voltFail <= 4'h0;
    tick(4);
    rchk("masked flag", 32'h1c, 32'h10);
    chk("masked irq", 1'b0, irq);
    wreg(32'h1c, 32'h10);
    ctrlTxOut <= 1'b0;
    tick(31990);
    chk("before timeout", 1'b0, phyTxIn);
    tick(20);
    chk("after timeout", 1'b1, phyTxIn);
    chk("timeout drive", 5'h0, enVec & 5'h18);
    rchk("timeout status", 32'hc, 32'h08);
    rchk("timeout flag", 32'h1c, 32'h08);
    chk("timeout irq", 1'b1, irq);
    ctrlTxOut <= 1'b1;
  endtask : t_irq

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : printVerdict

  // Quiet inputs, 20 cycles of reset, then the scenarios in order.
  initial begin
    sysRst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ctrlTxOut = 1'b1;
    txRouteData = 1'b0;
    cpuWait = 1'b0;
    cpuStopReq = 1'b0;
    regReduced = 1'b0;
    specialMode = 1'b0;
    pseudoSel = 1'b0;
    listenSel = 1'b0;
    remoteDom = 1'b0;
    voltFail = 4'h0;
    overCurrent = 2'h0;
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_normal();
    t_submodes();
    t_route();
    t_standby();
    t_irq();
    printVerdict();
  end
endmodule : cpmc_can_phy_mode_control_tb_top

`default_nettype wire
